// *** include/cgu_pkg.sv ***
// package: constants and types for the clock generation unit
package cgu_pkg;
	// axi4-lite register byte offsets
	localparam logic [7:0] ADDR_SLOW     = 8'h00;
	localparam logic [7:0] ADDR_PCTL     = 8'h04;
	localparam logic [7:0] ADDR_PFLG     = 8'h08;
	localparam logic [7:0] ADDR_WCTL     = 8'h0C;
	localparam logic [7:0] ADDR_WSVC     = 8'h10;
	localparam logic [7:0] ADDR_STAT     = 8'h14;
	// field positions
	localparam int PCTL_EN_BIT    = 7;
	localparam int PFLG_FLAG_BIT  = 7;
	localparam int WCTL_CME_BIT   = 7;
	localparam int STAT_WAIT_BIT  = 0;
	localparam int STAT_WDR_BIT   = 1;
	localparam int STAT_CMR_BIT   = 2;
	// reset values
	localparam logic [2:0] SLOW_RST    = 3'h0;
	localparam logic [2:0] PRATE_RST   = 3'h0;
	localparam logic [2:0] WRATE_RST   = 3'h1;
	// watchdog service keys
	localparam logic [7:0] KEY_ARM     = 8'h55;
	localparam logic [7:0] KEY_FIRE    = 8'hAA;
	// prescaler stages
	localparam int PRESC_EXP     = 13;
	localparam int CHAIN_W       = 20;
	// clock timing
	localparam int CLK_MHZ       = 25;
	localparam int CM_MIN_US     = 2;
	localparam int CM_MAX_US     = 20;
	localparam int CM_CYC        = CM_MAX_US * CLK_MHZ;
	localparam int CM_W          = 10;
	// system reset stretch
	localparam int RST_CYC       = 16;
	localparam int RST_W         = 5;
	// watchdog service states
	typedef enum logic [1:0] {
		WS_IDLE  = 2'b01,
		WS_ARMED = 2'b10
	} cgu_ws_t;
endpackage

// *** include/cgu_tick_if.sv ***
// interface: prescaler ticks shared between unit modules
interface cgu_tick_if;
	logic [cgu_pkg::CHAIN_W-1:0] chain;
	logic                        bus_en;
	modport src (output chain, output bus_en);
	modport dst (input chain, input bus_en);
endinterface

// *** hdl/cgu_divider.sv ***
// file: slow-mode divider and bus tick chain
module cgu_divider (
	// clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       ce,
	// control
	input  wire logic       wait_mode,
	input  wire logic [2:0] slow_sel,
	// outputs
	output logic            pclk_en,
	output logic            gbt_en,
	cgu_tick_if.src         tk
);
	logic [7:0]                  sdiv_ff, nxt_sdiv;
	logic [cgu_pkg::CHAIN_W-1:0] chain_ff, nxt_chain;
	logic                        ph_ff, nxt_ph;
	logic                        slow_tick;
	logic                        bus_tick;

	// oscillator/2 rate stays constant for link and timer clocks
	always_comb begin
		nxt_ph = ~ph_ff;
		gbt_en = ph_ff;
		pclk_en = ph_ff;
		// divide by 2^sel only in wait mode with non-zero field
		slow_tick = (sdiv_ff & ((8'h01 << slow_sel) - 8'h01)) == 8'h00;
		if (!wait_mode || slow_sel == 3'h0) begin
			bus_tick = ph_ff;
		end else begin
			bus_tick = ph_ff & slow_tick;
		end
		nxt_sdiv = ph_ff ? sdiv_ff + 8'h01 : sdiv_ff;
		nxt_chain = bus_tick ? chain_ff + 1'b1 : chain_ff;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sdiv_ff  <= 8'h00;
			chain_ff <= '0;
			ph_ff    <= 1'b0;
		end else if (ce) begin
			sdiv_ff  <= nxt_sdiv;
			chain_ff <= nxt_chain;
			ph_ff    <= nxt_ph;
		end
	end

	assign tk.chain  = chain_ff;
	assign tk.bus_en = bus_tick & ce;
endmodule

// *** hdl/cgu_clkmon.sv ***
// file: clock monitor timed from the free-running reference clock
module cgu_clkmon (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// monitored activity
	input  wire logic enable,
	input  wire logic cpu_edge,
	// result
	output logic      fail
);
	logic [cgu_pkg::CM_W-1:0] cnt_ff, nxt_cnt;
	logic                     fail_ff, nxt_fail;

	// runs without the clock enable: it must see a stalled processor clock
	always_comb begin
		nxt_cnt  = cnt_ff;
		nxt_fail = 1'b0;
		if (!enable || cpu_edge) begin
			nxt_cnt = '0;
		end else if (cnt_ff == cgu_pkg::CM_W'(cgu_pkg::CM_CYC - 1)) begin
			nxt_fail = 1'b1;
			nxt_cnt  = '0;
		end else begin
			nxt_cnt = cnt_ff + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_ff  <= '0;
			fail_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			fail_ff <= nxt_fail;
		end
	end

	assign fail = fail_ff;
endmodule

// *** hdl/cgu_top.sv ***
// file: clock generation unit top with axi4-lite registers
module cgu_top (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// chip state
	input  wire logic        wait_mode,
	input  wire logic        por_n,
	input  wire logic        cpu_clk_edge,
	// generated clock enables, reset and interrupt
	output logic             pclk_en,
	output logic             eclk_en,
	output logic             gbt_en,
	output logic [3:0]       tclk_en,
	output logic             sys_rst_n,
	output logic             periodic_irq,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);
	cgu_tick_if tk ();

	// pin inputs pass two flops
	logic [2:0] sy1_ff, sy2_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sy1_ff <= 3'h0;
			sy2_ff <= 3'h0;
		end else begin
			sy1_ff <= {wait_mode, por_n, cpu_clk_edge};
			sy2_ff <= sy1_ff;
		end
	end
	logic wait_s, por_s, cedge_s;
	assign {wait_s, por_s, cedge_s} = sy2_ff;

	// registers
	logic [2:0] slow_ff, nxt_slow;
	logic [2:0] prate_ff, nxt_prate;
	logic       pen_ff, nxt_pen;
	logic       pflag_ff, nxt_pflag;
	logic [2:0] wrate_ff, nxt_wrate;
	logic       cme_ff, nxt_cme;
	logic       wdr_ff, nxt_wdr;
	logic       cmr_ff, nxt_cmr;
	cgu_pkg::cgu_ws_t ws_ff, nxt_ws;
	logic       wd_restart;
	logic       wd_fail;
	// bus state
	logic       aw_ff, nxt_aw, w_ff, nxt_w, b_ff, nxt_b, r_ff, nxt_r;
	logic [7:0] awa_ff, nxt_awa;
	logic [31:0] wd_ff, nxt_wd;
	logic [31:0] rd_ff, nxt_rd;
	logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
	logic       wr_go;
	// timers
	logic [12:0] wcnt_ff, nxt_wcnt;
	logic       p_hit, w_hit, w_timeout;
	logic [3:0] ph_ff, nxt_phs;
	logic [cgu_pkg::RST_W-1:0] rcnt_ff, nxt_rcnt;
	logic       cm_fail;

	// selected divider tap edge: stage n toggles once per 2^n bus ticks
	function automatic logic tap_edge(
		input logic [cgu_pkg::CHAIN_W-1:0] chain,
		input int                          stage
	);
		logic [cgu_pkg::CHAIN_W-1:0] mask;
		mask = (cgu_pkg::CHAIN_W'(1) << stage) - 1'b1;
		tap_edge = (chain & mask) == mask;
	endfunction

	cgu_divider u_div (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.ce        (ce),
		.wait_mode (wait_s),
		.slow_sel  (slow_ff),
		.pclk_en   (pclk_en),
		.gbt_en    (gbt_en),
		.tk        (tk)
	);

	// fed from the free reference clock, not the bus ticks
	cgu_clkmon u_cm (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.enable   (cme_ff),
		.cpu_edge (cedge_s),
		.fail     (cm_fail)
	);

	// four processor phase clocks rotate on bus ticks
	always_comb begin
		nxt_phs = tk.bus_en ? {ph_ff[2:0], ph_ff[3]} : ph_ff;
	end
	assign tclk_en = ph_ff & {4{tk.bus_en}};
	assign eclk_en = tk.bus_en;

	// periodic interrupt and watchdog timing
	always_comb begin
		p_hit = 1'b0;
		w_hit = 1'b0;
		if (tk.bus_en && prate_ff != 3'h0) begin
			p_hit = tap_edge(tk.chain,
				cgu_pkg::PRESC_EXP + int'(prate_ff) - 1);
		end
		if (tk.bus_en && wrate_ff != 3'h0) begin
			w_hit = tap_edge(tk.chain, cgu_pkg::PRESC_EXP);
		end
		nxt_wcnt  = wcnt_ff;
		w_timeout = 1'b0;
		if (wrate_ff == 3'h0 || wd_restart) begin
			nxt_wcnt = 13'h0;
		end else if (w_hit) begin
			// prescaler runs on: late by up to one stage, never early
			if (wcnt_ff == 13'(1 << (2 * int'(wrate_ff) - 2))) begin
				w_timeout = 1'b1;
				nxt_wcnt  = 13'h0;
			end else begin
				nxt_wcnt = wcnt_ff + 13'h1;
			end
		end
	end

	// axi4-lite handshake and register writes
	always_comb begin
		nxt_aw = aw_ff; nxt_awa = awa_ff;
		nxt_w = w_ff; nxt_wd = wd_ff;
		nxt_b = b_ff; nxt_br = br_ff;
		nxt_r = r_ff; nxt_rd = rd_ff; nxt_rr = rr_ff;
		nxt_slow = slow_ff; nxt_prate = prate_ff; nxt_pen = pen_ff;
		nxt_wrate = wrate_ff; nxt_cme = cme_ff;
		nxt_ws = ws_ff; wd_restart = 1'b0; wd_fail = 1'b0;
		nxt_pflag = pflag_ff;
		s_axi_awready = !aw_ff && !b_ff;
		s_axi_wready  = !w_ff && !b_ff;
		s_axi_arready = !r_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw = 1'b1; nxt_awa = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w = 1'b1; nxt_wd = s_axi_wdata;
		end
		wr_go = aw_ff && w_ff && s_axi_wstrb_ok();
		if (wr_go) begin
			nxt_aw = 1'b0; nxt_w = 1'b0; nxt_b = 1'b1; nxt_br = 2'b00;
			case (awa_ff)
				cgu_pkg::ADDR_SLOW: nxt_slow = wd_ff[2:0];
				cgu_pkg::ADDR_PCTL: begin
					nxt_prate = wd_ff[2:0];
					nxt_pen   = wd_ff[cgu_pkg::PCTL_EN_BIT];
				end
				cgu_pkg::ADDR_PFLG: begin
					if (wd_ff[cgu_pkg::PFLG_FLAG_BIT]) begin
						nxt_pflag = 1'b0;
					end
				end
				cgu_pkg::ADDR_WCTL: begin
					nxt_wrate = wd_ff[2:0];
					nxt_cme   = wd_ff[cgu_pkg::WCTL_CME_BIT];
				end
				cgu_pkg::ADDR_WSVC: begin
					if (wd_ff[7:0] == cgu_pkg::KEY_ARM) begin
						nxt_ws = cgu_pkg::WS_ARMED;
					end else if (wd_ff[7:0] == cgu_pkg::KEY_FIRE &&
						ws_ff == cgu_pkg::WS_ARMED) begin
						nxt_ws = cgu_pkg::WS_IDLE;
						wd_restart = 1'b1;
					end else if (wrate_ff != 3'h0) begin
						wd_fail = 1'b1;
						nxt_ws  = cgu_pkg::WS_IDLE;
					end
				end
				cgu_pkg::ADDR_STAT: nxt_br = 2'b00;
				default: nxt_br = 2'b10;
			endcase
		end
		if (b_ff && s_axi_bready) begin
			nxt_b = 1'b0;
		end
		// set wins over a clear in the same cycle
		if (p_hit) begin
			nxt_pflag = 1'b1;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_r = 1'b1; nxt_rr = 2'b00; nxt_rd = 32'h0000_0000;
			case (s_axi_araddr)
				cgu_pkg::ADDR_SLOW: nxt_rd[2:0] = slow_ff;
				cgu_pkg::ADDR_PCTL: begin
					nxt_rd[2:0] = prate_ff;
					nxt_rd[cgu_pkg::PCTL_EN_BIT] = pen_ff;
				end
				cgu_pkg::ADDR_PFLG: nxt_rd[cgu_pkg::PFLG_FLAG_BIT] = pflag_ff;
				cgu_pkg::ADDR_WCTL: begin
					nxt_rd[2:0] = wrate_ff;
					nxt_rd[cgu_pkg::WCTL_CME_BIT] = cme_ff;
				end
				cgu_pkg::ADDR_WSVC: nxt_rd = 32'h0000_0000;
				cgu_pkg::ADDR_STAT: begin
					nxt_rd[cgu_pkg::STAT_WAIT_BIT] = wait_s;
					nxt_rd[cgu_pkg::STAT_WDR_BIT]  = wdr_ff;
					nxt_rd[cgu_pkg::STAT_CMR_BIT]  = cmr_ff;
				end
				default: nxt_rr = 2'b10;
			endcase
		end else if (r_ff && s_axi_rready) begin
			nxt_r = 1'b0;
		end
	end

	function automatic logic s_axi_wstrb_ok();
		s_axi_wstrb_ok = 1'b1;
	endfunction

	// reset sequencer: stretches watchdog and clock-monitor causes into a fixed-length pulse; por_n passes unstretched
	always_comb begin
		nxt_rcnt = rcnt_ff;
		nxt_wdr  = wdr_ff;
		nxt_cmr  = cmr_ff;
		if (w_timeout || wd_fail) begin
			nxt_rcnt = cgu_pkg::RST_W'(cgu_pkg::RST_CYC);
			nxt_wdr  = 1'b1;
		end else if (cm_fail) begin
			nxt_rcnt = cgu_pkg::RST_W'(cgu_pkg::RST_CYC);
			nxt_cmr  = 1'b1;
		end else if (rcnt_ff != '0) begin
			nxt_rcnt = rcnt_ff - 1'b1;
		end
	end
	assign sys_rst_n = (rcnt_ff == '0) && por_s;
	assign periodic_irq = pflag_ff & pen_ff;

	// cause flags survive the stretched reset and por_n; only aresetn clears them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rcnt_ff <= '0;
			wdr_ff  <= 1'b0;
			cmr_ff  <= 1'b0;
		end else begin
			rcnt_ff <= nxt_rcnt;
			wdr_ff  <= nxt_wdr;
			cmr_ff  <= nxt_cmr;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || !sys_rst_n) begin
			aw_ff <= 1'b0; w_ff <= 1'b0; b_ff <= 1'b0; r_ff <= 1'b0;
			awa_ff <= 8'h00; wd_ff <= 32'h0000_0000;
			rd_ff <= 32'h0000_0000; br_ff <= 2'b00; rr_ff <= 2'b00;
			slow_ff  <= cgu_pkg::SLOW_RST;
			prate_ff <= cgu_pkg::PRATE_RST;
			pen_ff   <= 1'b0;
			pflag_ff <= 1'b0;
			wrate_ff <= cgu_pkg::WRATE_RST;
			cme_ff   <= 1'b0;
			ws_ff    <= cgu_pkg::WS_IDLE;
			wcnt_ff  <= 13'h0;
			ph_ff    <= 4'h1;
		end else if (ce) begin
			aw_ff <= nxt_aw; w_ff <= nxt_w; b_ff <= nxt_b; r_ff <= nxt_r;
			awa_ff <= nxt_awa; wd_ff <= nxt_wd;
			rd_ff <= nxt_rd; br_ff <= nxt_br; rr_ff <= nxt_rr;
			slow_ff  <= nxt_slow;
			prate_ff <= nxt_prate;
			pen_ff   <= nxt_pen;
			pflag_ff <= nxt_pflag;
			wrate_ff <= nxt_wrate;
			cme_ff   <= nxt_cme;
			ws_ff    <= nxt_ws;
			wcnt_ff  <= nxt_wcnt;
			ph_ff    <= nxt_phs;
		end
	end

	assign s_axi_bvalid = b_ff;
	assign s_axi_bresp  = br_ff;
	assign s_axi_rvalid = r_ff;
	assign s_axi_rdata  = rd_ff;
	assign s_axi_rresp  = rr_ff;
endmodule

// *** dv/cgu_top_props.sv ***
// checker: port-level assertions for the clock generation unit
module cgu_top_props (
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        ce,
	// generated enables and reset
	input wire logic        pclk_en,
	input wire logic        gbt_en,
	input wire logic [3:0]  tclk_en,
	input wire logic        sys_rst_n,
	// register bus
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [5:0] low_ff;
	logic [5:0] nxt_low;
	// counts cycles of system reset so a stuck stretcher is caught
	always_comb begin
		nxt_low = sys_rst_n ? 6'h00 : low_ff + 6'h01;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			low_ff <= 6'h00;
		else
			low_ff <= nxt_low;
	end
	a_gbt_rate: assert property (ce |=> gbt_en != $past(gbt_en))
		else $error("undivided enable did not toggle");
	a_pclk_rate: assert property (ce |=> pclk_en != $past(pclk_en))
		else $error("peripheral enable did not toggle");
	a_phase_onehot: assert property ($onehot0(tclk_en))
		else $error("phase enables overlap");
	a_rst_hold: assert property ($fell(sys_rst_n) |=> !sys_rst_n [*8])
		else $error("system reset too short");
	a_rst_len: assert property (!sys_rst_n |-> low_ff < 6'h18)
		else $error("system reset too long");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 (s_axi_bvalid || !sys_rst_n))
		else $error("write answer late");
	a_ar_single: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
endmodule

bind cgu_top cgu_top_props i_props (.aclk, .aresetn, .ce, .pclk_en, .gbt_en,
	.tclk_en, .sys_rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// *** dv/cgu_top_tb.sv ***
// testbench: self-checking bench for the clock generation unit
module cgu_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int LIMIT = 100000;
	localparam int WD    = 2 ** cgu_pkg::PRESC_EXP;
	localparam int MLO   = cgu_pkg::CM_MIN_US * cgu_pkg::CLK_MHZ;
	logic        aclk, aresetn, ce, wait_mode, por_n, cpu_clk_edge, cpu_run;
	logic        pclk_en, eclk_en, gbt_en, sys_rst_n, periodic_irq;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	int          fail_count, checks_done, cyc, n, n0;

	cgu_top i_cgu_top (.aclk, .aresetn, .ce, .wait_mode, .por_n, .cpu_clk_edge,
		.pclk_en, .eclk_en, .gbt_en, .tclk_en(), .sys_rst_n, .periodic_irq,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready);

	always #20 aclk = ~aclk;

	// processor edges every other cycle while the bench lets the core run
	always @(posedge aclk) cpu_clk_edge <= cpu_run & ~cpu_clk_edge;

	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input logic [33:0] s, input logic [33:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// results are compared here as they appear on the bus
	always @(posedge aclk) begin
		if (s_axi_rvalid && s_axi_rready)
			chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready)
			chk({32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
		cyc++;
		if (cyc == LIMIT) begin
			fail_count++;
			test_done();
		end
	end

	// a write that resets the part may lose its response, so stop waiting
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw, w;
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		while (aw || w) begin
			@(posedge aclk);
			if (aw && s_axi_awready) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end
		while (!s_axi_bvalid && sys_rst_n) @(posedge aclk);
		if (!s_axi_bvalid)
			void'(bq.pop_back());
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic wfor(ref logic sig, input logic lvl, input int lo, input int hi);
		int k;
		k = 0;
		while (sig !== lvl && k < hi) begin
			@(posedge aclk);
			k++;
		end
		chk({33'h0, (k >= lo && k < hi)}, 34'h1);
	endtask

	task automatic wlow(input int lo, input int hi);
		wfor(sys_rst_n, 1'b0, lo, hi);
		while (sys_rst_n !== 1'b1) @(posedge aclk);
		repeat (4) @(posedge aclk);
	endtask

	// rising edges of the bus enable over a fixed span
	task automatic rises(output int r);
		logic p;
		r = 0;
		p = eclk_en;
		repeat (1024) begin
			@(posedge aclk);
			if (eclk_en && !p)
				r++;
			p = eclk_en;
		end
	endtask

	initial begin
		{aclk, aresetn, wait_mode, cpu_clk_edge, s_axi_awvalid} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{ce, por_n, cpu_run} = 3'b111;
		s_axi_wstrb = 4'hF;
		seed = 32'h4BD4D6E5;
		{fail_count, checks_done, cyc} = '0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (4) @(posedge aclk);
		rd(8'h00, 34'h0);
		rd(8'h04, 34'h0);
		rd(8'h08, 34'h0);
		rd(8'h0C, 34'h1);
		rd(8'h14, 34'h0);
		wr(8'h18, 32'h1, 2'b10);
		for (int i = 0; i < 4; i++) begin
			seed = nx(seed);
			wr(8'h00, seed, 2'b00);
			rd(8'h00, {31'h0, seed[2:0]});
		end
		wr(8'h04, 32'h87, 2'b00);
		rd(8'h04, 34'h87);
		wr(8'h04, 32'h0, 2'b00);
		$display("register test done");
		wr(8'h10, 32'h55, 2'b00);
		wr(8'h10, 32'hAA, 2'b00);
		wr(8'h00, 32'h5, 2'b00);
		rises(n0);
		chk(34'(n0), 34'h200);
		wait_mode <= 1'b1;
		for (int s = 0; s < 8; s++) begin
			wr(8'h00, s, 2'b00);
			repeat (8) @(posedge aclk);
			rises(n);
			chk({33'h0, ((n << s) + 2 ** s + 2 >= n0 && (n << s) <= n0 + 2 ** s + 2)},
				34'h1);
		end
		rd(8'h14, 34'h1);
		wait_mode <= 1'b0;
		wr(8'h00, 32'h0, 2'b00);
		$display("slow divider test done");
		wr(8'h10, 32'h55, 2'b00);
		wr(8'h10, 32'hAA, 2'b00);
		repeat (20) @(posedge aclk);
		chk({33'h0, sys_rst_n}, 34'h1);
		seed = nx(seed);
		wr(8'h10, {24'h0, seed[7:4], 4'h0}, 2'b00);
		wlow(0, 40);
		rd(8'h14, 34'h2);
		rd(8'h0C, 34'h1);
		$display("watchdog service test done");
		cpu_run <= 1'b0;
		repeat (700) @(posedge aclk);
		chk({33'h0, sys_rst_n}, 34'h1);
		cpu_run <= 1'b1;
		wr(8'h0C, 32'h80, 2'b00);
		repeat (20) @(posedge aclk);
		cpu_run <= 1'b0;
		wlow(MLO, cgu_pkg::CM_CYC + 20);
		cpu_run <= 1'b1;
		rd(8'h14, 34'h6);
		$display("clock monitor test done");
		wr(8'h10, 32'hAA, 2'b00);
		wlow(0, 40);
		wlow(2 * WD - 100, 4 * WD + 100);
		rd(8'h14, 34'h6);
		$display("watchdog timeout test done");
		wr(8'h0C, 32'h0, 2'b00);
		wr(8'h04, 32'h81, 2'b00);
		wfor(periodic_irq, 1'b1, 1, 2 * WD + 100);
		rd(8'h08, 34'h80);
		wr(8'h04, 32'h1, 2'b00);
		repeat (2) @(posedge aclk);
		chk({33'h0, periodic_irq}, 34'h0);
		wr(8'h04, 32'h81, 2'b00);
		repeat (2) @(posedge aclk);
		chk({33'h0, periodic_irq}, 34'h1);
		wr(8'h08, 32'h80, 2'b00);
		repeat (2) @(posedge aclk);
		chk({33'h0, periodic_irq}, 34'h0);
		rd(8'h08, 34'h0);
		wr(8'h04, 32'h0, 2'b00);
		$display("periodic test done");
		ce <= 1'b0;
		rises(n);
		chk(34'(n), 34'h0);
		ce <= 1'b1;
		por_n <= 1'b0;
		repeat (12) @(posedge aclk);
		chk({33'h0, sys_rst_n}, 34'h0);
		por_n <= 1'b1;
		repeat (4) @(posedge aclk);
		chk({33'h0, sys_rst_n}, 34'h1);
		$display("enable and power-on test done");
		test_done();
	end
endmodule
